// ---- hdl/gpedg_pkg.sv ----
// Constants, register map and types of the eight-pin port with edge interrupts
// Functional notes
// - Ordinary pins reset undriven: alternate, digital enable, pull-up, pull-down all off.
// - Debug pins reset with alternate function, digital enable and pull-up set.
// - Power-on and external pin reset both restore every default configuration.
// - Direction 0 makes an input captured; direction 1 drives stored data.
// - Data register accesses use address bits nine to two as bit mask.
// - Data register spans 256 word locations, one per mask combination.
// - Data writes change only bits whose mask address bit is one.
// - Data reads return zero for bits whose mask address bit is zero.
// - All enabled pin interrupt conditions combine into one interrupt output.
// - Edge interrupts stay latched until software clears them.
// - Trigger is chosen from per-pin sense, both-edges and polarity settings.
// - Per-pin mask bit gates that pin onto the combined interrupt.
// - Raw status ignores the mask; masked status shows only unmasked conditions.
// - Writing one to a clear bit clears it; writing zero does nothing.
// - Alternate-function bit hands pin control to the peripheral, else software data.
// - Protected alternate bits change only when unlocked and their commit bit set.
// - Only the five debug pins, port B bit 7 and port C 3:0, are protected.
// - Per-pin pad settings for drive, open-drain, pulls, slew, enable reach the pad.
// - Fixed read-only words: eight peripheral identity and four cell identity.
// - Alternate, pull-up and enable reset to 0x80 on port B, 0x0F on C.
// - Commit register resets to 0x7F on port B and 0xF0 on port C.
// - Writes to unconnected bit positions have no effect.
package gpedg_pkg;
	localparam int ADDR_W = 12;
	localparam int PINS = 8;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	localparam logic [11:0] OFF_DIR = 12'h400;
	localparam logic [11:0] OFF_IS = 12'h404;
	localparam logic [11:0] OFF_IBE = 12'h408;
	localparam logic [11:0] OFF_IEV = 12'h40c;
	localparam logic [11:0] OFF_IM = 12'h410;
	localparam logic [11:0] OFF_RIS = 12'h414;
	localparam logic [11:0] OFF_MIS = 12'h418;
	localparam logic [11:0] OFF_ICR = 12'h41c;
	localparam logic [11:0] OFF_AFSEL = 12'h420;
	localparam logic [11:0] OFF_DR2 = 12'h500;
	localparam logic [11:0] OFF_DR4 = 12'h504;
	localparam logic [11:0] OFF_DR8 = 12'h508;
	localparam logic [11:0] OFF_ODR = 12'h50c;
	localparam logic [11:0] OFF_PUR = 12'h510;
	localparam logic [11:0] OFF_PDR = 12'h514;
	localparam logic [11:0] OFF_SLR = 12'h518;
	localparam logic [11:0] OFF_DEN = 12'h51c;
	localparam logic [11:0] OFF_LOCK = 12'h520;
	localparam logic [11:0] OFF_CR = 12'h524;
	localparam logic [11:0] OFF_PID = 12'hfd0;
	localparam logic [11:0] OFF_CID = 12'hff0;
	localparam logic [7:0] DBG_MASK_B = 8'h80;
	localparam logic [7:0] DBG_MASK_C = 8'h0f;
	localparam logic [7:0] RST_DR2 = 8'hff;
	localparam logic [31:0] UNLOCK_KEY = 32'h5a5a_c3c3;
	// Identity values are arbitrary
	localparam logic [7:0] PERIPH_ID [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
	localparam logic [7:0] CELL_ID [4] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d};
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [4:0] {
		RG_NONE, RG_DATA, RG_DIR, RG_IS, RG_IBE, RG_IEV, RG_IM, RG_RIS, RG_MIS, RG_ICR,
		RG_AFSEL, RG_DR2, RG_DR4, RG_DR8, RG_ODR, RG_PUR, RG_PDR, RG_SLR, RG_DEN,
		RG_LOCK, RG_CR, RG_PID, RG_CID
	} gpedg_reg_t;
endpackage

// ---- hdl/gpedg_sync.sv ----
// Three-stage pad input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module gpedg_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cen,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1, s2, s3;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else if (cen) begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Only stages two and three are compared; stage one may be metastable
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge aclk) begin
			if (!aresetn)
				dout[i] <= 1'b0;
			else if (cen && (s2[i] == s3[i]))
				dout[i] <= s3[i];
		end
	end
endmodule // gpedg_sync
`default_nettype wire

// ---- hdl/gpedg_port.sv ----
// One eight-pin port: AXI4-Lite registers, pad control, edge/level interrupts
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module gpedg_port
	import gpedg_pkg::*;
#(
	parameter int PORT_INDEX = 0,
	parameter logic [7:0] CONNECTED = 8'hff
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cen,
	// AXI4-Lite write
	input wire logic [gpedg_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [gpedg_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Pads
	input wire logic [gpedg_pkg::PINS-1:0] pad_in,
	output logic [gpedg_pkg::PINS-1:0] pad_out,
	output logic [gpedg_pkg::PINS-1:0] pad_oe_n,
	// Pad configuration
	output logic [gpedg_pkg::PINS-1:0] alt_function_select,
	output logic [gpedg_pkg::PINS-1:0] digital_enable_bits,
	output logic [gpedg_pkg::PINS-1:0] pullup_enable_bits,
	output logic [gpedg_pkg::PINS-1:0] pulldown_enable_bits,
	output logic [gpedg_pkg::PINS-1:0] drive_low_strength_select,
	output logic [gpedg_pkg::PINS-1:0] drive_mid_strength_select,
	output logic [gpedg_pkg::PINS-1:0] drive_high_strength_select,
	output logic [gpedg_pkg::PINS-1:0] open_drain_select,
	output logic [gpedg_pkg::PINS-1:0] slew_rate_select,
	// Peripheral side
	input wire logic [gpedg_pkg::PINS-1:0] alt_out,
	input wire logic [gpedg_pkg::PINS-1:0] alt_oe,
	output logic [gpedg_pkg::PINS-1:0] alt_in,
	// Interrupt
	output logic irq
);
	import gpedg_pkg::*;

	// Debug pins of this instance
	localparam logic [7:0] DBG = (PORT_INDEX == PORT_B) ? DBG_MASK_B :
		(PORT_INDEX == PORT_C) ? DBG_MASK_C : 8'h00;

	logic [7:0] pin_value_register, pin_direction_bits;
	logic [7:0] irq_sense_select, irq_any_edge_select, irq_polarity_select;
	logic [7:0] irq_mask_bits, irq_raw_state, irq_masked_state;
	logic [7:0] protection_commit_bits;
	logic unlocked;
	logic [7:0] pad_val, pad_prev;
	logic [7:0] edge_hit, lvl_hit, clr_bits, w_mask, ar_mask;
	logic [7:0] next_drive, next_val;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire, ar_fire;
	gpedg_reg_t wsel, rsel;
	logic [31:0] rd_val;

	// Map a byte address to a register
	function automatic gpedg_reg_t decode(input logic [ADDR_W-1:0] a);
		logic [11:0] w;
		w = {a[11:2], 2'b00};
		if (w[11:10] == 2'b00)
			return RG_DATA;
		if (w >= OFF_PID && w < OFF_CID)
			return RG_PID;
		if (w >= OFF_CID)
			return RG_CID;
		case (w)
			OFF_DIR: return RG_DIR;
			OFF_IS: return RG_IS;
			OFF_IBE: return RG_IBE;
			OFF_IEV: return RG_IEV;
			OFF_IM: return RG_IM;
			OFF_RIS: return RG_RIS;
			OFF_MIS: return RG_MIS;
			OFF_ICR: return RG_ICR;
			OFF_AFSEL: return RG_AFSEL;
			OFF_DR2: return RG_DR2;
			OFF_DR4: return RG_DR4;
			OFF_DR8: return RG_DR8;
			OFF_ODR: return RG_ODR;
			OFF_PUR: return RG_PUR;
			OFF_PDR: return RG_PDR;
			OFF_SLR: return RG_SLR;
			OFF_DEN: return RG_DEN;
			OFF_LOCK: return RG_LOCK;
			OFF_CR: return RG_CR;
			default: return RG_NONE;
		endcase
	endfunction

	// Merge write data, leaving unconnected positions untouched
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw);
		return (old & ~CONNECTED) | (nw & CONNECTED);
	endfunction

	gpedg_sync #(
		.W(PINS)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.cen(cen),
		.din(pad_in),
		.dout(pad_val)
	);

	// Write channel: address and data taken in either order
	assign wr_fire = !awready && !wready && !bvalid;
	assign wsel = decode(aw_addr);
	assign w_mask = aw_addr[9:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			aw_addr <= '0;
		end else if (cen) begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_addr <= awaddr;
			end else if (wr_fire)
				awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b1;
			w_data <= '0;
			w_strb <= '0;
		end else if (cen) begin
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_data <= wdata;
				w_strb <= wstrb;
			end else if (wr_fire)
				wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (cen) begin
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= (wsel == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (bready)
				bvalid <= 1'b0;
		end
	end

	// Byte lane 0 carries all eight-bit registers
	logic wr_lo;
	assign wr_lo = wr_fire && w_strb[0];

	always_ff @(posedge aclk) begin
		if (!aresetn)
			pin_value_register <= '0;
		else if (cen && wr_lo && wsel == RG_DATA)
			pin_value_register <= merge(pin_value_register,
				(pin_value_register & ~w_mask) | (w_data[7:0] & w_mask));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_direction_bits <= '0;
			irq_sense_select <= '0;
			irq_any_edge_select <= '0;
			irq_polarity_select <= '0;
			irq_mask_bits <= '0;
		end else if (cen && wr_lo) begin
			case (wsel)
				RG_DIR: pin_direction_bits <= merge(pin_direction_bits, w_data[7:0]);
				RG_IS: irq_sense_select <= merge(irq_sense_select, w_data[7:0]);
				RG_IBE: irq_any_edge_select <= merge(irq_any_edge_select, w_data[7:0]);
				RG_IEV: irq_polarity_select <= merge(irq_polarity_select, w_data[7:0]);
				RG_IM: irq_mask_bits <= merge(irq_mask_bits, w_data[7:0]);
				default: ;
			endcase
		end
	end

	// Pad settings; debug pins come up in their debug role
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			digital_enable_bits <= DBG;
			pullup_enable_bits <= DBG;
			pulldown_enable_bits <= '0;
			drive_low_strength_select <= RST_DR2;
			drive_mid_strength_select <= '0;
			drive_high_strength_select <= '0;
			open_drain_select <= '0;
			slew_rate_select <= '0;
		end else if (cen && wr_lo) begin
			case (wsel)
				RG_DEN: digital_enable_bits <= merge(digital_enable_bits, w_data[7:0]);
				RG_PUR: pullup_enable_bits <= merge(pullup_enable_bits, w_data[7:0]);
				RG_PDR: pulldown_enable_bits <= merge(pulldown_enable_bits, w_data[7:0]);
				RG_DR2: drive_low_strength_select <= merge(drive_low_strength_select, w_data[7:0]);
				RG_DR4: drive_mid_strength_select <= merge(drive_mid_strength_select, w_data[7:0]);
				RG_DR8: drive_high_strength_select <= merge(drive_high_strength_select, w_data[7:0]);
				RG_ODR: open_drain_select <= merge(open_drain_select, w_data[7:0]);
				RG_SLR: slew_rate_select <= merge(slew_rate_select, w_data[7:0]);
				default: ;
			endcase
		end
	end

	// Key written with all lanes unlocks; any other value locks again
	always_ff @(posedge aclk) begin
		if (!aresetn)
			unlocked <= 1'b0;
		else if (cen && wr_fire && wsel == RG_LOCK)
			unlocked <= (w_data == UNLOCK_KEY) && (w_strb == 4'hf);
	end

	// Commit bits of unprotected pins are fixed at one
	always_ff @(posedge aclk) begin
		if (!aresetn)
			protection_commit_bits <= ~DBG;
		else if (cen && wr_lo && wsel == RG_CR && unlocked)
			protection_commit_bits <= (protection_commit_bits & ~DBG) | (w_data[7:0] & DBG & CONNECTED);
	end

	// Protected bits need unlock plus commit before a write lands
	logic [7:0] af_ok;
	assign af_ok = ~DBG | (protection_commit_bits & {8{unlocked}});

	always_ff @(posedge aclk) begin
		if (!aresetn)
			alt_function_select <= DBG;
		else if (cen && wr_lo && wsel == RG_AFSEL)
			alt_function_select <= merge(alt_function_select,
				(alt_function_select & ~af_ok) | (w_data[7:0] & af_ok));
	end

	// Interrupt detection on synchronised pad values
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pad_prev <= '0;
		else if (cen)
			pad_prev <= pad_val;
	end

	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			if (irq_any_edge_select[i])
				edge_hit[i] = pad_val[i] ^ pad_prev[i];
			else if (irq_polarity_select[i])
				edge_hit[i] = pad_val[i] & ~pad_prev[i];
			else
				edge_hit[i] = ~pad_val[i] & pad_prev[i];
			lvl_hit[i] = irq_polarity_select[i] ? pad_val[i] : ~pad_val[i];
		end
	end

	assign clr_bits = (wr_lo && wsel == RG_ICR) ? w_data[7:0] & CONNECTED : 8'h00;

	// Level bits follow the pin; edge bits hold, and a new edge beats a clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_raw_state <= '0;
		else if (cen)
			irq_raw_state <= CONNECTED & ((irq_sense_select & lvl_hit) |
				(~irq_sense_select & ((irq_raw_state & ~clr_bits) | edge_hit)));
	end

	assign irq_masked_state = irq_raw_state & irq_mask_bits;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else if (cen)
			irq <= |irq_masked_state;
	end

	// Pad drive; disabled digital pins never drive
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			next_val[i] = alt_function_select[i] ? alt_out[i] : pin_value_register[i];
			next_drive[i] = digital_enable_bits[i] &
				(alt_function_select[i] ? alt_oe[i] : pin_direction_bits[i]);
			if (open_drain_select[i])
				next_drive[i] = next_drive[i] & ~next_val[i];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_out <= '0;
			pad_oe_n <= '1;
			alt_in <= '0;
		end else if (cen) begin
			pad_out <= next_val & ~open_drain_select;
			pad_oe_n <= ~next_drive;
			alt_in <= pad_val;
		end
	end

	// Read channel: one cycle to rvalid
	assign ar_fire = arvalid && arready;
	assign rsel = decode(araddr);
	assign ar_mask = araddr[9:2];

	always_comb begin
		rd_val = 32'h0000_0000;
		case (rsel)
			RG_DATA: rd_val[7:0] = ((pin_value_register & pin_direction_bits) |
				(pad_val & ~pin_direction_bits)) & ar_mask & CONNECTED;
			RG_DIR: rd_val[7:0] = pin_direction_bits;
			RG_IS: rd_val[7:0] = irq_sense_select;
			RG_IBE: rd_val[7:0] = irq_any_edge_select;
			RG_IEV: rd_val[7:0] = irq_polarity_select;
			RG_IM: rd_val[7:0] = irq_mask_bits;
			RG_RIS: rd_val[7:0] = irq_raw_state;
			RG_MIS: rd_val[7:0] = irq_masked_state;
			RG_AFSEL: rd_val[7:0] = alt_function_select;
			RG_DR2: rd_val[7:0] = drive_low_strength_select;
			RG_DR4: rd_val[7:0] = drive_mid_strength_select;
			RG_DR8: rd_val[7:0] = drive_high_strength_select;
			RG_ODR: rd_val[7:0] = open_drain_select;
			RG_PUR: rd_val[7:0] = pullup_enable_bits;
			RG_PDR: rd_val[7:0] = pulldown_enable_bits;
			RG_SLR: rd_val[7:0] = slew_rate_select;
			RG_DEN: rd_val[7:0] = digital_enable_bits;
			RG_LOCK: rd_val[0] = ~unlocked;
			RG_CR: rd_val[7:0] = protection_commit_bits;
			RG_PID: rd_val[7:0] = PERIPH_ID[{~araddr[4], araddr[3:2]}];
			RG_CID: rd_val[7:0] = CELL_ID[araddr[3:2]];
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (cen) begin
			if (ar_fire) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rd_val;
				rresp <= (rsel == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_data_write;
		cen && wr_fire && w_strb[0] && wsel == RG_DATA;
	endsequence

	sequence s_data_read;
		cen && ar_fire && rsel == RG_DATA;
	endsequence

	a_reset_defaults: assert property (!$past(aresetn) |->
		alt_function_select == DBG && pullup_enable_bits == DBG && pulldown_enable_bits == 8'h00)
		else $error("port defaults wrong after reset");

	a_mask_write: assert property (s_data_write |=>
		((pin_value_register ^ $past(pin_value_register)) & ~$past(w_mask)) == 8'h00)
		else $error("unmasked data bit changed");

	a_mask_read: assert property (s_data_read |=> rvalid && (rdata[7:0] & ~$past(ar_mask)) == 8'h00)
		else $error("unmasked data bit read as one");

	a_edge_hold: assert property (cen |=>
		($past(irq_raw_state) & ~$past(irq_sense_select) & ~$past(clr_bits) & ~irq_raw_state) == 8'h00)
		else $error("edge status dropped without clear");

	a_clear_bits: assert property (cen && clr_bits != 8'h00 && edge_hit == 8'h00 |=>
		(irq_raw_state & $past(clr_bits) & ~$past(irq_sense_select)) == 8'h00)
		else $error("clear did not clear edge status");

	a_level_track: assert property (cen |=>
		((irq_raw_state ^ $past(lvl_hit)) & $past(irq_sense_select) & CONNECTED) == 8'h00)
		else $error("level status does not follow pin");

	a_irq_combine: assert property (cen |=> irq == |($past(irq_raw_state) & $past(irq_mask_bits)))
		else $error("port interrupt wrong");

	a_commit_guard: assert property (cen && wr_fire && wsel == RG_AFSEL && !unlocked |=>
		((alt_function_select ^ $past(alt_function_select)) & DBG) == 8'h00)
		else $error("protected alternate bit changed while locked");

	a_no_drive_off: assert property (cen |=> (~pad_oe_n & ~$past(digital_enable_bits)) == 8'h00)
		else $error("pad driven without digital enable");

	a_write_resp: assert property (cen && wr_fire |=> bvalid && awready && wready)
		else $error("write response missing");
endmodule // gpedg_port
`default_nettype wire

// ---- testbench/gpedg_pad_model.sv ----
// Pad and outside-world model resolving each pin level
`timescale 1ns/100ps
`default_nettype none
module gpedg_pad_model (
	// Clock
	input wire logic aclk,
	// Device side
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe_n,
	input wire logic [7:0] pull_up_en,
	input wire logic [7:0] pull_down_en,
	// Outside sources
	input wire logic [7:0] ext_level,
	input wire logic [7:0] ext_drive,
	// Resolved level
	output logic [7:0] pad_in
);
	logic [7:0] floating;
	// Undriven pin without pull wanders, so no stale value looks valid
	always_ff @(posedge aclk) begin
		floating <= ~pad_in;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pad_oe_n[i]) begin
				pad_in[i] = pad_out[i];
			end else if (ext_drive[i]) begin
				pad_in[i] = ext_level[i];
			end else if (pull_up_en[i]) begin
				pad_in[i] = 1'b1;
			end else if (pull_down_en[i]) begin
				pad_in[i] = 1'b0;
			end else begin
				pad_in[i] = floating[i];
			end
		end
	end
endmodule // gpedg_pad_model
`default_nettype wire

// ---- testbench/test_gpedg_port.sv ----
// Register-level testbench of one port instance (debug pin on bit 7)
`timescale 1ns/100ps
`default_nettype none
module test_gpedg_port;
	import gpedg_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
	logic bready = 1, rready = 1, awready, wready, bvalid, arready, rvalid, irq;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] pad_in, pad_out, pad_oe_n, afs, den, pu, pd, dr2, dr4, dr8, odr, slr, alt_in;
	logic [7:0] alt_out = 8'h00, alt_oe = 8'h00, ext_level = 8'h00, ext_drive = 8'hff;
	logic [31:0] rd;
	int mismatches = 0, n_compared = 0, cycles = 0;
	always #5 aclk = ~aclk;
	gpedg_port #(.PORT_INDEX(PORT_B), .CONNECTED(8'hff)) dut_u (.aclk(aclk), .aresetn(aresetn), .cen(1'b1),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe_n(pad_oe_n), .alt_function_select(afs), .digital_enable_bits(den),
		.pullup_enable_bits(pu), .pulldown_enable_bits(pd), .drive_low_strength_select(dr2),
		.drive_mid_strength_select(dr4), .drive_high_strength_select(dr8), .open_drain_select(odr),
		.slew_rate_select(slr), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .irq(irq));
	gpedg_pad_model pads_u (.aclk(aclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_up_en(pu), .pull_down_en(pd),
		.ext_level(ext_level), .ext_drive(ext_drive), .pad_in(pad_in));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Bready and rready stay high, so back-to-back calls never retoggle them
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bit aw_done, w_done;
		aw_done = 0;
		w_done = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		forever begin
			@(posedge aclk);
			if (bvalid) begin
				resp = bresp;
				break;
			end
			if (!aw_done && awready) begin
				awvalid <= 0;
				aw_done = 1;
			end
			if (!w_done && wready) begin
				wvalid <= 0;
				w_done = 1;
			end
		end
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		bit ar_done;
		ar_done = 0;
		araddr <= a;
		arvalid <= 1;
		forever begin
			@(posedge aclk);
			if (rvalid) begin
				rd = rdata;
				resp = rresp;
				break;
			end
			if (!ar_done && arready) begin
				arvalid <= 0;
				ar_done = 1;
			end
		end
		chk(rd, exp);
	endtask
	task automatic do_reset();
		aresetn <= 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		repeat (3) @(posedge aclk);
	endtask
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		do_reset();
		chk({afs, den, pu, pd}, {8'h80, 8'h80, 8'h80, 8'h00});
		chk({dr2, pad_oe_n}, {8'hff, 8'hff});
		rd_chk(OFF_AFSEL, 32'h80);
		rd_chk(OFF_DEN, 32'h80);
		rd_chk(OFF_CR, 32'h7f);
		rd_chk(OFF_PDR, 32'h00);
		for (int i = 0; i < 8; i++) rd_chk(OFF_PID + 12'(4 * i), {24'h0, PERIPH_ID[i]});
		for (int i = 0; i < 4; i++) rd_chk(OFF_CID + 12'(4 * i), {24'h0, CELL_ID[i]});
		rd_chk(12'h600, 32'h0);
		chk(resp, RESP_SLVERR);
		// Masked data writes and reads with the device driving
		wr(OFF_DEN, 32'hff);
		wr(OFF_DIR, 32'hff);
		wr(12'h3fc, 32'h00);
		wr(12'h098, 32'heb);
		rd_chk(12'h3fc, 32'h22);
		rd_chk(12'h0c4, 32'h20);
		chk({pad_oe_n[6:0], pad_out[6:0]}, {7'h00, 7'h22});
		// Input capture through the synchroniser
		ext_level <= 8'h5a;
		wr(OFF_DIR, 32'h00);
		repeat (6) @(posedge aclk);
		rd_chk(12'h3fc, 32'h5a);
		rd_chk(12'h1a4, 32'h48);
		chk(alt_in, 8'h5a);
		// Masked while trigger settings change
		ext_level <= 8'h08;
		wr(OFF_IM, 32'h00);
		wr(OFF_IS, 32'h02);
		wr(OFF_IBE, 32'h04);
		wr(OFF_IEV, 32'h03);
		repeat (6) @(posedge aclk);
		wr(OFF_ICR, 32'hff);
		rd_chk(OFF_RIS, 32'h00);
		ext_level <= 8'h07;
		repeat (6) @(posedge aclk);
		rd_chk(OFF_RIS, 32'h0f);
		rd_chk(OFF_MIS, 32'h00);
		chk(irq, 1'b0);
		wr(OFF_IM, 32'h05);
		repeat (2) @(posedge aclk);
		rd_chk(OFF_MIS, 32'h05);
		chk(irq, 1'b1);
		ext_level <= 8'h00;
		repeat (6) @(posedge aclk);
		rd_chk(OFF_RIS, 32'h0d);
		wr(OFF_ICR, 32'h01);
		rd_chk(OFF_RIS, 32'h0c);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b1);
		wr(OFF_ICR, 32'h0c);
		rd_chk(OFF_MIS, 32'h00);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		wr(OFF_RIS, 32'hff);
		rd_chk(OFF_RIS, 32'h00);
		// Commit protection of the debug pin
		wr(OFF_AFSEL, 32'h01);
		rd_chk(OFF_AFSEL, 32'h81);
		wr(OFF_LOCK, UNLOCK_KEY);
		rd_chk(OFF_LOCK, 32'h00);
		wr(OFF_CR, 32'hff);
		rd_chk(OFF_CR, 32'hff);
		wr(OFF_AFSEL, 32'h01);
		rd_chk(OFF_AFSEL, 32'h01);
		// Peripheral takes pin 0
		alt_out <= 8'h01;
		alt_oe <= 8'h01;
		repeat (3) @(posedge aclk);
		chk({pad_oe_n[0], pad_out[0]}, 2'b01);
		alt_oe <= 8'h00;
		repeat (3) @(posedge aclk);
		chk(pad_oe_n[0], 1'b1);
		// Pad settings reach the pad
		wr(OFF_DR4, 32'h3c);
		wr(OFF_DR8, 32'h81);
		wr(OFF_PDR, 32'h11);
		wr(OFF_SLR, 32'h42);
		wr(OFF_ODR, 32'h18);
		chk({dr4, dr8, pd, slr}, 32'h3c811142);
		chk(odr, 8'h18);
		// Released pin 5 must read high through its pull-up
		wr(OFF_PUR, 32'h20);
		ext_drive <= 8'hdf;
		repeat (6) @(posedge aclk);
		rd_chk(12'h0fc, 32'h20);
		ext_drive <= 8'hff;
		// Second reset in mid-run
		do_reset();
		chk({afs, den, pu, dr4}, {8'h80, 8'h80, 8'h80, 8'h00});
		rd_chk(OFF_CR, 32'h7f);
		rd_chk(OFF_LOCK, 32'h01);
		print_verdict();
	end
endmodule // test_gpedg_port
`default_nettype wire
